// ---- ddir_consts.svh ----
// Register offsets, field positions and reset values of the drive interface register bank.
`ifndef DDIR_CONSTS_SVH
`define DDIR_CONSTS_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define DDIR_OFF_SELECT    4'h0
`define DDIR_OFF_CYLHIGH   4'h1
`define DDIR_OFF_CYLLOW    4'h2
`define DDIR_OFF_HEAD      4'h3
`define DDIR_OFF_CONTROL   4'h4
`define DDIR_OFF_STATUS    4'h5
`define DDIR_OFF_SECTOR    4'h6
`define DDIR_OFF_MODEL     4'h7
`define DDIR_OFF_IRQSTAT   4'h8
`define DDIR_OFF_IRQMASK   4'h9

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define DDIR_SEL_PORT_HI   6
`define DDIR_SEL_PORT_LO   5
`define DDIR_SEL_DRV_HI    2
`define DDIR_CYL_HI_MSB    1
`define DDIR_HEAD_MSB      4
`define DDIR_CTL_RELEASE   7
`define DDIR_CTL_RTZ       6
`define DDIR_CTL_FCLR      4
`define DDIR_CTL_OFSAWAY   3
`define DDIR_CTL_OFSTOWARD 2
`define DDIR_CTL_LATE      1
`define DDIR_CTL_EARLY     0
`define DDIR_ST_ATTN       7
`define DDIR_ST_DPB        6
`define DDIR_ST_SEEKERR    5
`define DDIR_ST_UNUSED     4
`define DDIR_ST_WPROT      3
`define DDIR_ST_FAULT      2
`define DDIR_ST_ACCBUSY    1
`define DDIR_ST_READY      0
`define DDIR_MDL_FAMILY    7
`define DDIR_MDL_CODE_HI   2

// ----------------------------------------------------------------------
// Masks and reset values
// ----------------------------------------------------------------------
`define DDIR_SEL_WMASK     8'h67
`define DDIR_CYLH_WMASK    8'h03
`define DDIR_HEAD_WMASK    8'h1f
`define DDIR_MDL_FIXMASK   8'h07
`define DDIR_REG_RESET     8'h00
`define DDIR_IRQ_EVENTS    4
`define DDIR_IRQ_WMASK     8'h0f
`define DDIR_PULSE_CYCLES  4'h4

`endif

// ---- ddir_pkg.sv ----
// Types shared by the drive interface register bank.
package ddir_pkg;
    typedef logic [7:0] ddir_byte_t;
    typedef logic [3:0] ddir_addr_t;
    // Command pulse sequencer states, Gray coded.
    typedef enum logic [1:0] {
        DDIR_IDLE  = 2'b00,
        DDIR_PULSE = 2'b01,
        DDIR_HOLD  = 2'b11
    } ddir_pulse_e;
endpackage : ddir_pkg

// ---- ddir_pulse.sv ----
// Stretches a one-cycle command request into a fixed-width drive pulse.
`timescale 1ns/1ns
`include "ddir_consts.svh"
module ddir_pulse
    import ddir_pkg::*;
(
    input  wire logic clk_sys,
    input  wire logic rst,
    input  wire logic start,
    output logic      pulseOut
);
    ddir_pulse_e state;
    ddir_pulse_e next_state;
    logic [3:0]  count;
    wire         countDone = (count == `DDIR_PULSE_CYCLES);

    // Next state; a request while busy is absorbed so pulses never overlap.
    always_comb begin
        next_state = state;
        case (state)
            DDIR_IDLE:  if (start) next_state = DDIR_PULSE;
            DDIR_PULSE: if (countDone) next_state = DDIR_HOLD;
            DDIR_HOLD:  next_state = DDIR_IDLE;
            default:    next_state = DDIR_IDLE;
        endcase
    end

    // State, counter and registered output.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state    <= DDIR_IDLE;
            count    <= 4'h0;
            pulseOut <= 1'b0;
        end else begin
            state    <= next_state;
            count    <= (next_state == DDIR_PULSE) ? count + 4'h1 : 4'h0;
            pulseOut <= (next_state == DDIR_PULSE);
        end
    end
endmodule : ddir_pulse

// ---- ddir_regs.sv ----
// Byte-wide register bank between the controller processor and an attached disk drive.
`timescale 1ns/1ns
`include "ddir_consts.svh"
module ddir_regs
    import ddir_pkg::*;
(
    input  wire logic       clk_sys,
    input  wire logic       rst,
    input  wire logic [3:0] regAddr,
    input  wire logic [7:0] regWrData,
    input  wire logic       regWrite,
    input  wire logic       regRead,
    output logic      [7:0] regRdData,
    output logic      [1:0] portSelect,
    output logic      [2:0] driveSelect,
    output logic      [9:0] cylinderAddr,
    output logic      [4:0] headNumber,
    output logic            releaseReservation,
    output logic            returnToTrackZero,
    output logic            faultClear,
    output logic            offsetAway,
    output logic            offsetToward,
    output logic            lateStrobe,
    output logic            earlyStrobe,
    input  wire logic [7:0] driveStatusIn,
    input  wire logic [7:0] sectorCountIn,
    input  wire logic [7:0] driveModelIn,
    output logic            irq
);
    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    function automatic logic hit(input ddir_addr_t a, input ddir_addr_t off);
        hit = (a == off);
    endfunction : hit

    wire wrSelect  = regWrite & hit(regAddr, `DDIR_OFF_SELECT);
    wire wrCylHigh = regWrite & hit(regAddr, `DDIR_OFF_CYLHIGH);
    wire wrCylLow  = regWrite & hit(regAddr, `DDIR_OFF_CYLLOW);
    wire wrHead    = regWrite & hit(regAddr, `DDIR_OFF_HEAD);
    wire wrControl = regWrite & hit(regAddr, `DDIR_OFF_CONTROL);
    wire wrIrqStat = regWrite & hit(regAddr, `DDIR_OFF_IRQSTAT);
    wire wrIrqMask = regWrite & hit(regAddr, `DDIR_OFF_IRQMASK);

    // ------------------------------------------------------------------
    // Output registers
    // ------------------------------------------------------------------
    ddir_byte_t selectReg;
    ddir_byte_t cylHighReg;
    ddir_byte_t cylLowReg;
    ddir_byte_t headReg;
    ddir_byte_t controlReg;

    // Return-to-zero and fault-clear are one-cycle requests from a control write.
    wire rtzReq   = wrControl & regWrData[`DDIR_CTL_RTZ];
    wire fclrReq  = wrControl & regWrData[`DDIR_CTL_FCLR];

    // Bits 4..3 of the selection byte are masked so they always hold zero.
    // port field stored.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            selectReg <= `DDIR_REG_RESET;
        end else if (wrSelect) begin
            selectReg <= regWrData & `DDIR_SEL_WMASK;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cylHighReg <= `DDIR_REG_RESET;
            cylLowReg  <= `DDIR_REG_RESET;
        end else begin
            if (wrCylHigh) cylHighReg <= regWrData & `DDIR_CYLH_WMASK;
            if (wrCylLow)  cylLowReg  <= regWrData;
        end
    end

    // A head write in the same cycle as return-to-zero loses: the seek home wins.
    // head register clear.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            headReg <= `DDIR_REG_RESET;
        end else if (rtzReq) begin
            headReg <= `DDIR_REG_RESET;
        end else if (wrHead) begin
            headReg <= regWrData & `DDIR_HEAD_WMASK;
        end
    end

    // Level bits of control are held; the action bits are pulsed separately.
    // offset levels held.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            controlReg <= `DDIR_REG_RESET;
        end else if (wrControl) begin
            controlReg <= regWrData;
        end
    end

    // ------------------------------------------------------------------
    // Drive command pulses
    // ------------------------------------------------------------------
    logic rtzPulse;
    logic fclrPulse;
    logic relPulse;

    ddir_pulse u_rtz (
        .clk_sys  (clk_sys),
        .rst      (rst),
        .start    (rtzReq),
        .pulseOut (rtzPulse)
    );

    // The drive clears its latch only if the fault has gone; we just request.
    // fault clear pulse.
    ddir_pulse u_fclr (
        .clk_sys  (clk_sys),
        .rst      (rst),
        .start    (fclrReq),
        .pulseOut (fclrPulse)
    );

    // Release is stretched like the other commands, so the drive sees a pulse
    // of the same width whichever command the processor issues.
    ddir_pulse u_rel (
        .clk_sys  (clk_sys),
        .rst      (rst),
        .start    (wrControl & regWrData[`DDIR_CTL_RELEASE]),
        .pulseOut (relPulse)
    );

    // ------------------------------------------------------------------
    // Drive-side outputs
    // ------------------------------------------------------------------
    // Drive-side outputs are registered copies so they come from flip-flops.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            portSelect         <= 2'h0;
            driveSelect        <= 3'h0;
            cylinderAddr       <= 10'h000;
            headNumber         <= 5'h00;
            releaseReservation <= 1'b0;
            returnToTrackZero  <= 1'b0;
            faultClear         <= 1'b0;
            offsetAway         <= 1'b0;
            offsetToward       <= 1'b0;
            lateStrobe         <= 1'b0;
            earlyStrobe        <= 1'b0;
        end else begin
            portSelect         <= selectReg[`DDIR_SEL_PORT_HI:`DDIR_SEL_PORT_LO];
            driveSelect        <= selectReg[`DDIR_SEL_DRV_HI:0];
            cylinderAddr       <= {cylHighReg[`DDIR_CYL_HI_MSB:0], cylLowReg};
            headNumber         <= headReg[`DDIR_HEAD_MSB:0];
            releaseReservation <= relPulse;
            returnToTrackZero  <= rtzPulse;
            faultClear         <= fclrPulse;
            offsetAway         <= controlReg[`DDIR_CTL_OFSAWAY];
            offsetToward       <= controlReg[`DDIR_CTL_OFSTOWARD];
            lateStrobe         <= controlReg[`DDIR_CTL_LATE];
            earlyStrobe        <= controlReg[`DDIR_CTL_EARLY];
        end
    end

    // ------------------------------------------------------------------
    // Input registers
    // ------------------------------------------------------------------
    ddir_byte_t statusReg;
    ddir_byte_t sectorReg;
    ddir_byte_t modelReg;
    logic       seekErrLatch;

    // The seek error is latched here and dropped by return-to-zero.
    // The clear is held for the whole seek-home pulse, because the drive
    // keeps reporting the error until it has seen that pulse; clearing only
    // on the write would leave the latch stuck. A reported error still wins.
    // seek error latch clear.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            seekErrLatch <= 1'b0;
        end else if (driveStatusIn[`DDIR_ST_SEEKERR]) begin
            seekErrLatch <= 1'b1;
        end else if (rtzReq | rtzPulse) begin
            seekErrLatch <= 1'b0;
        end
    end

    // Status is sampled every cycle; bit 4 is forced to zero.
    // attention sampled.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            statusReg <= `DDIR_REG_RESET;
            sectorReg <= `DDIR_REG_RESET;
            modelReg  <= `DDIR_REG_RESET;
        end else begin
            statusReg <= {driveStatusIn[7:6], seekErrLatch, 1'b0, driveStatusIn[3:0]};
            sectorReg <= sectorCountIn;
            modelReg  <= {driveModelIn[`DDIR_MDL_FAMILY], 4'h0,
                          driveModelIn[`DDIR_MDL_CODE_HI:0]};
        end
    end

    // ------------------------------------------------------------------
    // Interrupts
    // ------------------------------------------------------------------
    // Events: 0 attention, 1 seek error, 2 fault, 3 ready rose.
    // Only the event bits are flip-flops; the upper status bits read zero.
    logic [`DDIR_IRQ_EVENTS-1:0] irqBits;
    ddir_byte_t irqStat;
    ddir_byte_t irqMask;
    logic [`DDIR_IRQ_EVENTS-1:0] evNow;
    logic [`DDIR_IRQ_EVENTS-1:0] evPrev;
    wire  [`DDIR_IRQ_EVENTS-1:0] evRise = evNow & ~evPrev;

    assign evNow = {statusReg[`DDIR_ST_READY], statusReg[`DDIR_ST_FAULT],
                    statusReg[`DDIR_ST_SEEKERR], statusReg[`DDIR_ST_ATTN]};

    // Sticky bits: a set in the clearing cycle wins over the write-one clear.
    // attention prompts status check.
    genvar gi;
    generate
        for (gi = 0; gi < `DDIR_IRQ_EVENTS; gi = gi + 1) begin : g_irq
            always_ff @(posedge clk_sys or posedge rst) begin
                if (rst) begin
                    irqBits[gi] <= 1'b0;
                    evPrev[gi]  <= 1'b0;
                end else begin
                    evPrev[gi]  <= evNow[gi];
                    if (evRise[gi]) irqBits[gi] <= 1'b1;
                    else if (wrIrqStat & regWrData[gi]) irqBits[gi] <= 1'b0;
                end
            end
        end
    endgenerate
    assign irqStat = {4'h0, irqBits};

    // ------------------------------------------------------------------
    // Interrupt mask and line
    // ------------------------------------------------------------------
    // The line is registered so it comes straight from a flip-flop; it
    // therefore follows a status or mask change one cycle late.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            irqMask <= `DDIR_REG_RESET;
            irq     <= 1'b0;
        end else begin
            if (wrIrqMask) irqMask <= regWrData & `DDIR_IRQ_WMASK;
            irq <= |(irqStat & irqMask);
        end
    end

    // ------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------
    // Write-only registers read back zero, as do unmapped addresses.
    // processor reads inputs.
    ddir_byte_t rdMux;
    always_comb begin
        case (regAddr)
            `DDIR_OFF_STATUS:  rdMux = statusReg;
            `DDIR_OFF_SECTOR:  rdMux = sectorReg;
            `DDIR_OFF_MODEL:   rdMux = modelReg;
            `DDIR_OFF_IRQSTAT: rdMux = irqStat;
            `DDIR_OFF_IRQMASK: rdMux = irqMask;
            default:           rdMux = 8'h00;
        endcase
    end

    // Read data stand only in the cycle after each read strobe cycle and are zero otherwise, so a
    // processor that samples late sees zero rather than stale data.
    // The mux is registered, which costs the one cycle of read latency.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            regRdData <= 8'h00;
        end else begin
            regRdData <= regRead ? rdMux : 8'h00;
        end
    end
endmodule : ddir_regs

// ---- ddir_regs_props.sv ----
// Concurrent checks on the ports of the drive interface register bank.
`timescale 1ns/1ns
module ddir_regs_props
    import ddir_pkg::*;
(
    input wire logic       clk_sys,
    input wire logic       rst,
    input wire logic [3:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic       regWrite,
    input wire logic       regRead,
    input wire logic [7:0] regRdData,
    input wire logic [1:0] portSelect,
    input wire logic [2:0] driveSelect,
    input wire logic [9:0] cylinderAddr,
    input wire logic [4:0] headNumber,
    input wire logic       returnToTrackZero,
    input wire logic       offsetAway,
    input wire logic       offsetToward,
    input wire logic       lateStrobe,
    input wire logic       earlyStrobe,
    input wire logic [7:0] driveStatusIn,
    input wire logic [7:0] driveModelIn,
    input wire logic       irq
);
    // Cycles since the last control write; pulse checks skip overlapping requests.
    logic [2:0] sinceCtl;
    wire        ctlWr = regWrite && regAddr == 4'h4;
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            sinceCtl <= 3'h7;
        end else begin
            sinceCtl <= ctlWr ? 3'h0 : sinceCtl + {2'h0, sinceCtl != 3'h7};
        end
    end

    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);

    a_sel_fields: assert property (
        regWrite && regAddr == 4'h0 ##1 !(regWrite && regAddr == 4'h0) [*2] |->
        {portSelect, driveSelect} == {$past(regWrData[6:5], 2), $past(regWrData[2:0], 2)})
        else $error("select fields wrong");
    a_cyl_low: assert property (
        regWrite && regAddr == 4'h2 ##1 !(regWrite && regAddr == 4'h2) [*2] |->
        cylinderAddr[7:0] == $past(regWrData, 2))
        else $error("cylinder low bits wrong");
    a_rtz_head_clear: assert property (
        ctlWr && regWrData[6] ##1 !(regWrite && regAddr == 4'h3) [*2] |-> headNumber == 5'h00)
        else $error("head not cleared by return to zero");
    a_rtz_pulse: assert property (
        ctlWr && regWrData[6] && sinceCtl == 3'h7 |->
        ##2 returnToTrackZero [*4] ##1 !returnToTrackZero)
        else $error("return to zero pulse wrong");
    a_ctl_levels: assert property (
        ctlWr ##1 !ctlWr [*2] |->
        {offsetAway, offsetToward, lateStrobe, earlyStrobe} == $past(regWrData[3:0], 2))
        else $error("offset or strobe level wrong");
    a_rd_idle: assert property (
        !regRead |=> regRdData == 8'h00)
        else $error("read data not zero when idle");
    a_rd_refused: assert property (
        regRead && (regAddr < 4'h5 || regAddr > 4'h9) |=> regRdData == 8'h00)
        else $error("refused read returned data");
    a_status_byte: assert property (
        regRead && regAddr == 4'h5 && $stable(driveStatusIn) && !$past(rst) |=>
        regRdData[7:6] == $past(driveStatusIn[7:6]) && !regRdData[4]
        && regRdData[3:0] == $past(driveStatusIn[3:0]))
        else $error("status byte wrong");
    a_model_byte: assert property (
        regRead && regAddr == 4'h7 && $stable(driveModelIn) && !$past(rst) |=>
        regRdData == {$past(driveModelIn[7]), 4'h0, $past(driveModelIn[2:0])})
        else $error("model byte wrong");
    a_irq_masked: assert property (
        regWrite && regAddr == 4'h9 && regWrData[3:0] == 4'h0
        ##1 !(regWrite && regAddr == 4'h9) [*2] |-> !irq)
        else $error("interrupt raised while masked");
endmodule : ddir_regs_props

bind ddir_regs ddir_regs_props i_props (.clk_sys, .rst, .regAddr, .regWrData, .regWrite,
    .regRead, .regRdData, .portSelect, .driveSelect, .cylinderAddr, .headNumber,
    .returnToTrackZero, .offsetAway, .offsetToward, .lateStrobe, .earlyStrobe,
    .driveStatusIn, .driveModelIn, .irq);

// ---- ddir_drive_model.sv ----
// Behavioural disk drive answering the register bank's drive side.
`timescale 1ns/1ns
module ddir_drive_model
    import ddir_pkg::*;
#(
    parameter int         CYL_LIMIT  = 822,
    parameter logic [2:0] MODEL_CODE = 3'h5 // Arbitrary model code.
)(
    input  wire logic       clk_sys,
    input  wire logic       rst,
    input  wire logic [9:0] cylinderAddr,
    input  wire logic       returnToTrackZero,
    input  wire logic       faultClear,
    input  wire logic       faultCause,
    input  wire logic       otherBusy,
    output logic      [7:0] driveStatusIn,
    output logic      [7:0] sectorCountIn,
    output logic      [7:0] driveModelIn
);
    logic seekErr;
    logic faultLatch;
    // Latches; a set condition still present wins over its clear.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            seekErr       <= 1'b0;
            faultLatch    <= 1'b0;
            sectorCountIn <= 8'h00;
        end else begin
            seekErr <= (cylinderAddr > CYL_LIMIT) || (seekErr && !returnToTrackZero);
            faultLatch <= faultCause || (faultLatch && !faultClear);
            // Sectors pass under the heads only while the carriage moves home.
            sectorCountIn <= sectorCountIn + {7'h00, returnToTrackZero};
        end
    end
    assign driveStatusIn = {seekErr | faultLatch, otherBusy, seekErr, 1'b0,
                            faultLatch, faultLatch, 1'b0, !faultLatch};
    assign driveModelIn = {1'b1, 4'h0, MODEL_CODE};
endmodule : ddir_drive_model

// ---- ddir_tb.sv ----
// Self-checking testbench for the drive interface register bank.
`timescale 1ns/1ns
`include "ddir_consts.svh"
module tb;
    import ddir_pkg::*;
    logic       clk_sys = 1'b0;
    logic       rst = 1'b1;
    logic [3:0] regAddr = 4'h0;
    logic [7:0] regWrData = 8'h00;
    logic       regWrite = 1'b0;
    logic       regRead = 1'b0;
    logic       faultCause = 1'b0;
    logic       otherBusy = 1'b0;
    logic [7:0] regRdData, driveStatusIn, sectorCountIn, driveModelIn, rdVal, s0;
    logic [1:0] portSelect;
    logic [2:0] driveSelect;
    logic [9:0] cylinderAddr;
    logic [4:0] headNumber;
    logic       releaseReservation, returnToTrackZero, faultClear, irq;
    logic       offsetAway, offsetToward, lateStrobe, earlyStrobe;
    logic [7:0] lfsr = 8'h46;
    logic [7:0] v[4];
    int         nFail = 0;
    int         comparisons = 0;
    int         rtzCnt = 0;
    int         fcCnt = 0;
    int         relCnt = 0;
    int         n0;

    ddir_regs i_dut (.clk_sys, .rst, .regAddr, .regWrData, .regWrite, .regRead, .regRdData,
        .portSelect, .driveSelect, .cylinderAddr, .headNumber, .releaseReservation,
        .returnToTrackZero, .faultClear, .offsetAway, .offsetToward, .lateStrobe,
        .earlyStrobe, .driveStatusIn, .sectorCountIn, .driveModelIn, .irq);
    ddir_drive_model i_drive (.clk_sys, .rst, .cylinderAddr, .returnToTrackZero,
        .faultClear, .faultCause, .otherBusy, .driveStatusIn, .sectorCountIn, .driveModelIn);

    // Clock and pulse-width counters.
    always #2 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        rtzCnt <= rtzCnt + int'(returnToTrackZero);
        fcCnt  <= fcCnt + int'(faultClear);
        relCnt <= relCnt + int'(releaseReservation);
    end

    function automatic logic [7:0] nextRand(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction : nextRand
    function automatic logic [7:0] expStatus(input logic sk, input logic f, input logic b);
        return {sk | f, b, sk, 1'b0, f, f, 1'b0, !f};
    endfunction : expStatus
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            nFail++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic idle(input int n);
        repeat (n) begin
            @(posedge clk_sys);
            regWrite <= 1'b0;
            regRead  <= 1'b0;
        end
    endtask : idle
    // A write holds its strobe until a later rd or idle lowers it; a following wr keeps it high.
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        regWrite  <= 1'b1;
        regRead   <= 1'b0;
        regAddr   <= a;
        regWrData <= d;
    endtask : wr
    task automatic rd(input logic [3:0] a);
        @(posedge clk_sys);
        regRead  <= 1'b1;
        regWrite <= 1'b0;
        regAddr  <= a;
        idle(1);
        @(posedge clk_sys);
        rdVal = regRdData;
    endtask : rd
    task automatic endSim;
        if (nFail == 0 && comparisons > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : endSim

    initial begin
        #80000;
        nFail++;
        endSim();
    end

    initial begin
        repeat (16) @(posedge clk_sys);
        rst <= 1'b0;
        idle(2);
        chk({portSelect, driveSelect, headNumber, irq, 5'h00}, 16'h0000);
        rd(4'h7);
        chk(16'(rdVal), 16'h0085);
        for (int a = 0; a < 16; a++) if (a < 5 || a > 9) begin
            rd(4'(a));
            chk(16'(rdVal), 16'h0000);
        end
        for (int k = 0; k < 12; k++) begin
            for (int i = 0; i < 4; i++) begin
                lfsr = nextRand(lfsr);
                v[i] = (k == 0) ? 8'hff : lfsr;
                wr(4'(i), v[i]);
            end
            idle(3);
            chk(16'({portSelect, driveSelect}), 16'({v[0][6:5], v[0][2:0]}));
            chk(16'(cylinderAddr), 16'({v[1][1:0], v[2]}));
            chk(16'(headNumber), 16'(v[3][4:0]));
        end
        for (int i = 0; i < 16; i++) begin
            wr(4'h4, 8'(i));
            idle(3);
            chk(16'({offsetAway, offsetToward, lateStrobe, earlyStrobe}), 16'(i));
        end
        wr(4'h1, 8'h00);
        wr(4'h2, 8'h00);
        wr(4'h4, 8'h40);
        idle(10);
        wr(4'h8, 8'hff);
        idle(3);
        rd(4'h8);
        chk(16'(rdVal), 16'h0000);
        wr(4'h9, 8'h02);
        wr(4'h1, 8'h03);
        wr(4'h2, 8'hff);
        idle(8);
        chk(16'(irq), 16'h0001);
        rd(4'h5);
        chk(16'(rdVal), 16'(expStatus(1'b1, 1'b0, 1'b0)));
        wr(4'h1, 8'h00);
        wr(4'h2, 8'h00);
        wr(4'h3, 8'h1f);
        rd(4'h6);
        s0 = rdVal;
        n0 = rtzCnt;
        wr(4'h4, 8'h40);
        idle(10);
        chk(16'(headNumber), 16'h0000);
        chk(16'(rtzCnt - n0), 16'(`DDIR_PULSE_CYCLES));
        rd(4'h5);
        chk(16'(rdVal), 16'(expStatus(1'b0, 1'b0, 1'b0)));
        rd(4'h6);
        chk(16'(rdVal), 16'(s0 + 8'h04));
        wr(4'h8, 8'hff);
        idle(3);
        chk(16'(irq), 16'h0000);
        // Fault while masked, clear refused while the cause stays, then accepted.
        wr(4'h9, 8'h00);
        faultCause <= 1'b1;
        idle(4);
        rd(4'h5);
        chk(16'(rdVal), 16'(expStatus(1'b0, 1'b1, 1'b0)));
        chk(16'(irq), 16'h0000);
        rd(4'h8);
        chk(16'(rdVal), 16'h0005);
        wr(4'h9, 8'h04);
        idle(3);
        chk(16'(irq), 16'h0001);
        n0 = fcCnt;
        wr(4'h4, 8'h10);
        idle(10);
        chk(16'(fcCnt - n0), 16'(`DDIR_PULSE_CYCLES));
        rd(4'h5);
        chk(16'(rdVal[2]), 16'h0001);
        faultCause <= 1'b0;
        wr(4'h4, 8'h10);
        idle(10);
        rd(4'h5);
        chk(16'(rdVal), 16'(expStatus(1'b0, 1'b0, 1'b0)));
        wr(4'h8, 8'h0d);
        idle(3);
        chk(16'(irq), 16'h0000);
        otherBusy <= 1'b1;
        idle(3);
        rd(4'h5);
        chk(16'(rdVal), 16'(expStatus(1'b0, 1'b0, 1'b1)));
        n0 = relCnt;
        wr(4'h4, 8'h80);
        idle(10);
        chk(16'(relCnt - n0), 16'(`DDIR_PULSE_CYCLES));
        endSim();
    end
endmodule : tb
